//--- verification/smsr_host_model.sv
// host side of the link: chip select, link clock and lanes, spi mode 0
// assumes the bench resolves the two-way lanes into io_wire
`timescale 1ns/1ps
module smsr_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] io_wire,
    output logic            cs_n,
    output logic            sck,
    output logic [3:0]      io_drv
);
    logic wp_level;

    initial begin
        cs_n     = 1'b1;
        sck      = 1'b0;
        io_drv   = 4'hc;
        wp_level = 1'b1;
    end

    // write-protect pin level, only meaningful outside quad mode
    task automatic set_wp(input logic v);
        @(posedge clk);
        wp_level  <= v;
        io_drv[2] <= v;
    endtask

    // one link clock period: low for 5 core clocks, high for 3
    task automatic tick(input logic [3:0] lanes, input int w,
                        output logic [3:0] seen);
        if (w == 4)
            io_drv <= lanes;
        else
            io_drv <= {1'b1, wp_level, lanes[1:0]};
        repeat (5) @(posedge clk);
        seen = io_wire;
        sck <= 1'b1;
        repeat (3) @(posedge clk);
        sck <= 1'b0;
    endtask

    // kind 0: opcode only, 1: opcode and one data byte, 2: read one byte
    task automatic xfer(input int w, input logic [7:0] op, input int kind,
                        input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] tx;
        logic [3:0]  lanes;
        logic [3:0]  seen;
        logic [3:0]  mask;
        int          n;
        int          per;
        per  = 8 / w;
        tx   = {op, wd};
        mask = 4'((1 << w) - 1);
        rd   = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (2) @(posedge clk);
        for (n = 0; n < per * (kind == 0 ? 1 : 2); n++) begin
            // released lanes show the inverse of their last value
            lanes = ~io_drv;
            if (n < per || kind == 1)
                lanes = (lanes & ~mask) |
                        (4'(tx >> (16 - w * (n + 1))) & mask);
            tick(lanes, w, seen);
            if (kind == 2 && n >= per)
                rd = 8'(rd << w) | 8'((w == 1) ? {3'h0, seen[1]} :
                                      (seen & mask));
        end
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule

//--- verification/smsr_status_one_bench.sv
// self-checking bench for the first status register and its decoder
// assumes the host model above and a 10 MHz core clock
`timescale 1ns/1ps
module smsr_status_one_bench;
    import smsr_pkg::*;

    logic       clk;
    logic       rst_n;
    logic       cs_n;
    logic       sck;
    logic       quad;
    logic       dual;
    logic       write_enable_latch;
    logic       status_write_protect_enable;
    logic [3:0] io_drv;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [3:0] io_wire;
    logic [1:0] lat;
    logic [1:0] bp;
    logic [7:0] rd;
    logic [7:0] wd;
    logic [7:0] flags;
    logic [7:0] m_nv;
    logic       m_quad;
    logic       m_dual;
    logic       m_wel;
    logic       m_wp;
    int         n_errors;
    int         tests_run;
    int         i;

    assign io_wire = (io_oe & io_o) | (~io_oe & io_drv);
    assign flags   = {status_write_protect_enable, quad, lat, bp, write_enable_latch, dual};

    smsr_status_one u_smsr_status_one (
        .CORE_CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck),
        .IO_I(io_wire), .IO_O(io_o), .IO_OE(io_oe), .QUAD_MODE(quad),
        .DUAL_MODE(dual), .WRITE_ENABLE(write_enable_latch), .STATUS_WP_EN(status_write_protect_enable),
        .LATENCY_SEL(lat), .BLOCK_PROTECT(bp)
    );

    smsr_host_model u_smsr_host_model (
        .clk(clk), .io_wire(io_wire), .cs_n(cs_n), .sck(sck),
        .io_drv(io_drv)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wp(input logic v);
        m_wp = v;
        u_smsr_host_model.set_wp(v);
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] d);
        int         w;
        int         kind;
        logic [7:0] exp1;
        w    = m_quad ? 4 : (m_dual ? 2 : 1);
        kind = (op == CMD_WRITE_STATUS) ? 1 :
               ((op == CMD_READ_STATUS || op == CMD_READ_STATUS2) ? 2 : 0);
        u_smsr_host_model.xfer(w, op, kind, d, rd);
        case (op)
            CMD_SET_WRITE_LATCH:   m_wel = 1'b1;
            CMD_CLEAR_WRITE_LATCH: m_wel = 1'b0;
            CMD_ENTER_QUAD_MODE: begin
                m_quad = 1'b1;
                m_dual = 1'b0;
            end
            CMD_ENTER_DUAL_MODE: begin
                m_quad = 1'b0;
                m_dual = 1'b1;
            end
            CMD_EXIT_WIDE_MODE: begin
                m_quad = 1'b0;
                m_dual = 1'b0;
            end
            CMD_WRITE_STATUS: begin
                if (m_wel && !(m_nv[7] && !m_wp && !m_quad))
                    m_nv = d & 8'hbc;
            end
            default: ;
        endcase
        exp1 = m_nv | {1'b0, m_quad, 4'h0, m_wel, 1'b0};
        if (op == CMD_READ_STATUS)
            check(rd, exp1);
        if (op == CMD_READ_STATUS2)
            check(rd, {1'b0, m_quad, m_dual, 5'h00});
        exp1 = {m_nv[7], m_quad, m_nv[5:2], m_wel, m_dual};
        check(flags, exp1);
        // lanes must be released once the frame has ended
        check({4'h0, io_oe}, 8'h00);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial begin
        rst_n     = 1'b0;
        n_errors  = 0;
        tests_run = 0;
        m_nv      = {NV_INIT[4], 1'b0, NV_INIT[3:0], 2'h0};
        m_quad    = 1'b0;
        m_dual    = 1'b0;
        m_wel     = 1'b0;
        m_wp      = 1'b1;
        wd        = 8'h00;
        void'($urandom(73));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_READ_STATUS2, 8'h00);
        cmd(CMD_WRITE_STATUS, 8'hbc);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_SET_WRITE_LATCH, 8'h00);
        for (i = 0; i < 6; i++) begin
            wd = 8'($urandom()) & 8'h7f;
            cmd(CMD_WRITE_STATUS, wd);
            cmd(CMD_READ_STATUS, 8'h00);
        end
        cmd(CMD_WRITE_STATUS, wd | 8'hc3);
        wp(1'b0);
        cmd(CMD_WRITE_STATUS, 8'h00);
        cmd(CMD_READ_STATUS, 8'h00);
        wp(1'b1);
        cmd(CMD_WRITE_STATUS, 8'h94);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_CLEAR_WRITE_LATCH, 8'h00);
        cmd(CMD_WRITE_STATUS, 8'h28);
        cmd(CMD_READ_STATUS, 8'h00);
        // reset in mid-run keeps the nonvolatile bits
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        m_wel  = 1'b0;
        m_quad = 1'b0;
        m_dual = 1'b0;
        repeat (3) @(posedge clk);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_SET_WRITE_LATCH, 8'h00);
        wp(1'b0);
        cmd(CMD_ENTER_QUAD_MODE, 8'h00);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_READ_STATUS2, 8'h00);
        cmd(CMD_WRITE_STATUS, 8'hff);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_ENTER_DUAL_MODE, 8'h00);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_READ_STATUS2, 8'h00);
        cmd(CMD_ENTER_QUAD_MODE, 8'h00);
        cmd(CMD_EXIT_WIDE_MODE, 8'h00);
        cmd(CMD_READ_STATUS, 8'h00);
        cmd(CMD_READ_STATUS2, 8'h00);
        stop_test();
    end
endmodule

//--- verilog/smsr_nv_store.sv
// nonvolatile cells of the status register, modelled as a register bank
// assumes power loss is modelled by the core reset, which it ignores
`timescale 1ns/1ps
module smsr_nv_store
    import smsr_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            we,
    input  wire logic [NV_W-1:0] wdata,
    output logic      [NV_W-1:0] rdata
);
    // contents survive reset; start value stands for the shipped state
    logic [NV_W-1:0] cell_q = NV_INIT;

    always_ff @(posedge clk) begin
        if (we) begin
            cell_q <= wdata;
        end
    end

    assign rdata = cell_q;
endmodule

//--- verilog/smsr_pkg.sv
// constants and types for the first serial-memory status register
// assumes a single-clock core that samples the serial pins itself
package smsr_pkg;

    localparam int LANES = 4;
    localparam int SR_W  = 8;
    localparam int NV_W  = 5;

    // command opcodes seen on the serial link
    localparam logic [7:0] CMD_SET_WRITE_LATCH   = 8'h06;
    localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS       = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS      = 8'h01;
    localparam logic [7:0] CMD_READ_STATUS2      = 8'h35;
    localparam logic [7:0] CMD_ENTER_QUAD_MODE   = 8'h38;
    localparam logic [7:0] CMD_ENTER_DUAL_MODE   = 8'h37;
    localparam logic [7:0] CMD_EXIT_WIDE_MODE    = 8'hff;

    // bit positions in the first status register
    localparam int BIT_WP_ENABLE = 7;
    localparam int BIT_QUAD_MODE = 6;
    localparam int BIT_LAT_HI    = 5;
    localparam int BIT_LAT_LO    = 4;
    localparam int BIT_BP_HI     = 3;
    localparam int BIT_BP_LO     = 2;
    localparam int BIT_WEL       = 1;
    // bit positions in the second status register
    localparam int BIT2_QUAD     = 6;
    localparam int BIT2_DUAL     = 5;

    // nonvolatile cell layout {wp_enable, lat_hi, lat_lo, bp_hi, bp_lo}
    localparam logic [4:0] NV_INIT = 5'h00;

    // values after reset, and the number of bits in a byte
    localparam logic       RST_WEL   = 1'b0;
    localparam logic       RST_QUAD  = 1'b0;
    localparam logic       RST_DUAL  = 1'b0;
    localparam logic [3:0] RST_IO    = 4'h0;
    localparam logic [2:0] RST_CNT   = 3'h0;
    localparam logic [7:0] RST_SHIFT = 8'h00;
    localparam logic [5:0] RST_PINS  = 6'h20;
    localparam int         BITS_PER_BYTE = 8;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_OPCODE = 5'h02,
        ST_WRDATA = 5'h04,
        ST_RDDATA = 5'h08,
        ST_IGNORE = 5'h10
    } smsr_state_t;

endpackage

//--- verilog/smsr_status_one.sv
// first status register of a serial memory, with its command decoder
// assumes the link clock is slow enough to be sampled by CORE_CLK
`timescale 1ns/1ps
module smsr_status_one
    import smsr_pkg::*;
(
    input  wire logic                       CORE_CLK,
    input  wire logic                       RST_N,
    input  wire logic                       CS_N,
    input  wire logic                       SCK,
    input  wire logic [smsr_pkg::LANES-1:0] IO_I,
    output logic      [smsr_pkg::LANES-1:0] IO_O,
    output logic      [smsr_pkg::LANES-1:0] IO_OE,
    output logic                            QUAD_MODE,
    output logic                            DUAL_MODE,
    output logic                            WRITE_ENABLE,
    output logic                            STATUS_WP_EN,
    output logic      [1:0]                 LATENCY_SEL,
    output logic      [1:0]                 BLOCK_PROTECT
);
    import smsr_pkg::*;

    // lane width for the current mode: 1, 2 or 4 bits per edge
    function automatic logic [2:0] lane_width(input logic quad,
                                              input logic dual);
        lane_width = quad ? 3'h4 : (dual ? 3'h2 : 3'h1);
    endfunction

    // shift one edge's worth of input lanes into a byte, msb first
    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                            input logic [3:0] io,
                                            input logic       quad,
                                            input logic       dual);
        if (quad) begin
            shift_in = {sh[3:0], io[3:0]};
        end else if (dual) begin
            shift_in = {sh[5:0], io[1:0]};
        end else begin
            shift_in = {sh[6:0], io[0]};
        end
    endfunction

    // pins for the current top bits of an outgoing byte
    function automatic logic [3:0] lane_out(input logic [7:0] sh,
                                            input logic       quad,
                                            input logic       dual);
        if (quad) begin
            lane_out = sh[7:4];
        end else if (dual) begin
            lane_out = {2'h0, sh[7:6]};
        end else begin
            lane_out = {2'h0, sh[7], 1'h0};
        end
    endfunction

    function automatic logic [3:0] lane_mask(input logic quad,
                                             input logic dual);
        lane_mask = quad ? 4'hf : (dual ? 4'h3 : 4'h2);
    endfunction

    // pin sampling
    logic [5:0]       pins_s;
    logic             cs_n_s;
    logic             sck_s;
    logic [3:0]       io_s;
    logic             sck_prev_q;

    smsr_sync #(
        .W       (6),
        .RST_VAL (RST_PINS)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .din   ({CS_N, SCK, IO_I}),
        .dout  (pins_s)
    );

    assign cs_n_s = pins_s[5];
    assign sck_s  = pins_s[4];
    assign io_s   = pins_s[3:0];

    // state
    smsr_state_t      state_q;
    smsr_state_t      state_d;
    logic [2:0]       cnt_q;
    logic [2:0]       cnt_d;
    logic [7:0]       in_sh_q;
    logic [7:0]       out_sh_q;
    logic [7:0]       out_sh_d;
    logic             rd_sel2_q;
    logic             wel_q;
    logic             wel_d;
    logic             quad_q;
    logic             quad_d;
    logic             dual_q;
    logic             dual_d;
    logic [3:0]       io_o_q;
    logic [3:0]       io_oe_q;
    logic [NV_W-1:0]  nv_rd;

    // edge detection and decode
    wire              sck_rise  = sck_s & ~sck_prev_q & ~cs_n_s;
    wire              sck_fall  = ~sck_s & sck_prev_q & ~cs_n_s;
    wire [2:0]        lanes     = lane_width(quad_q, dual_q);
    wire [3:0]        cnt_sum   = {1'b0, cnt_q} + {1'b0, lanes};
    wire              byte_end  = sck_rise && (cnt_sum == 4'(BITS_PER_BYTE));
    wire [7:0]        sh_next   = shift_in(in_sh_q, io_s, quad_q, dual_q);
    wire              in_opcode = (state_q == ST_IDLE)
                                || (state_q == ST_OPCODE);
    wire              op_done   = byte_end && in_opcode;
    wire              is_set_wl = sh_next == CMD_SET_WRITE_LATCH;
    wire              is_clr_wl = sh_next == CMD_CLEAR_WRITE_LATCH;
    wire              is_rd1    = sh_next == CMD_READ_STATUS;
    wire              is_rd2    = sh_next == CMD_READ_STATUS2;
    wire              is_write_status_cmd   = sh_next == CMD_WRITE_STATUS;
    wire              is_eq     = sh_next == CMD_ENTER_QUAD_MODE;
    wire              is_ed     = sh_next == CMD_ENTER_DUAL_MODE;
    wire              is_ex     = sh_next == CMD_EXIT_WIDE_MODE;
    wire              write_status_cmd_done = byte_end && (state_q == ST_WRDATA);
    // write-protect pin shares lane 2, so it only counts outside quad mode
    wire              wp_low    = ~quad_q & ~io_s[2];
    wire              wr_block  = ~wel_q | (nv_rd[4] & wp_low);
    wire              nv_we     = write_status_cmd_done & ~wr_block;
    // only protect, latency and block-protect bits are taken
    wire [NV_W-1:0]   nv_wdata  = {sh_next[BIT_WP_ENABLE],
                                   sh_next[BIT_LAT_HI:BIT_BP_LO]};
    wire [7:0]        status1   = {nv_rd[4], quad_q, nv_rd[3:0],
                                   wel_q, 1'b0};
    wire [7:0]        status2   = {1'b0, quad_q, dual_q, 5'h00};
    wire              rd_first  = op_done && (is_rd1 || is_rd2);
    wire              rd_again  = byte_end && (state_q == ST_RDDATA);
    wire              rd_use2   = rd_first ? is_rd2 : rd_sel2_q;
    wire [7:0]        load_val  = rd_use2 ? status2 : status1;
    wire              out_step  = sck_fall && (state_q == ST_RDDATA);

    smsr_nv_store u_nv (
        .clk   (CORE_CLK),
        .we    (nv_we),
        .wdata (nv_wdata),
        .rdata (nv_rd)
    );

    // command sequencing
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (cs_n_s) begin
            state_d = ST_IDLE;
            cnt_d   = RST_CNT;
        end else begin
            if (sck_rise) begin
                cnt_d = cnt_sum[2:0];
            end
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_OPCODE;
                    if (op_done) begin
                        state_d = is_write_status_cmd ? ST_WRDATA :
                                  (rd_first ? ST_RDDATA : ST_IGNORE);
                    end
                end
                ST_OPCODE: begin
                    if (op_done) begin
                        state_d = is_write_status_cmd ? ST_WRDATA :
                                  (rd_first ? ST_RDDATA : ST_IGNORE);
                    end
                end
                ST_WRDATA: begin
                    if (write_status_cmd_done) begin
                        state_d = ST_IGNORE;
                    end
                end
                ST_RDDATA: state_d = ST_RDDATA;
                ST_IGNORE: state_d = ST_IGNORE;
                default:   state_d = ST_IDLE;
            endcase
        end
    end

    // volatile flags
    always_comb begin
        wel_d  = wel_q;
        quad_d = quad_q;
        dual_d = dual_q;
        if (op_done) begin
            if (is_set_wl) begin
                wel_d = 1'b1;
            end
            if (is_clr_wl) begin
                wel_d = 1'b0;
            end
            if (is_eq) begin
                quad_d = 1'b1;
                dual_d = 1'b0;
            end
            if (is_ex || is_ed) begin
                quad_d = 1'b0;
            end
            if (is_ed) begin
                dual_d = 1'b1;
            end
            if (is_ex) begin
                dual_d = 1'b0;
            end
        end
        // write-status data and completed writes leave the latch alone
    end

    always_comb begin
        out_sh_d = out_sh_q;
        if (rd_first || rd_again) begin
            out_sh_d = load_val;
        end else if (out_step) begin
            out_sh_d = out_sh_q << lanes;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            cnt_q   <= RST_CNT;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sck_prev_q <= 1'b0;
            in_sh_q    <= RST_SHIFT;
            out_sh_q   <= RST_SHIFT;
            rd_sel2_q  <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            in_sh_q    <= sck_rise ? sh_next : in_sh_q;
            out_sh_q   <= out_sh_d;
            rd_sel2_q  <= rd_first ? is_rd2 : rd_sel2_q;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wel_q  <= RST_WEL;
            quad_q <= RST_QUAD;
            dual_q <= RST_DUAL;
        end else begin
            wel_q  <= wel_d;
            quad_q <= quad_d;
            dual_q <= dual_d;
        end
    end

    // output lanes: data change on the falling link edge
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            io_o_q  <= RST_IO;
            io_oe_q <= RST_IO;
        end else if (cs_n_s) begin
            io_o_q  <= RST_IO;
            io_oe_q <= RST_IO;
        end else if (out_step) begin
            io_o_q  <= lane_out(out_sh_q, quad_q, dual_q);
            io_oe_q <= lane_mask(quad_q, dual_q);
        end
    end

    assign IO_O          = io_o_q;
    assign IO_OE         = io_oe_q;
    assign QUAD_MODE     = quad_q;
    assign DUAL_MODE     = dual_q;
    assign WRITE_ENABLE  = wel_q;
    assign STATUS_WP_EN  = nv_rd[4];
    assign LATENCY_SEL   = nv_rd[3:2];
    assign BLOCK_PROTECT = nv_rd[1:0];

    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    chk_nv_holds: assert property (
        !nv_we |=> $stable(nv_rd))
        else $error("nonvolatile bits changed without a status write");

    chk_wr_blocked: assert property (
        write_status_cmd_done && (!wel_q || (nv_rd[4] && wp_low)) |=> $stable(nv_rd))
        else $error("status write went through while protected");

    chk_wr_update: assert property (
        write_status_cmd_done && wel_q && !(nv_rd[4] && wp_low)
        |=> nv_rd == {$past(sh_next[7]), $past(sh_next[5:2])})
        else $error("status write stored wrong bits");

    chk_quad_keep: assert property (
        write_status_cmd_done |=> quad_q == $past(quad_q))
        else $error("status write changed the quad flag");

    chk_wel_keep: assert property (
        write_status_cmd_done |=> wel_q == $past(wel_q))
        else $error("status write changed the write enable latch");

    chk_wel_set: assert property (
        op_done && is_set_wl |=> wel_q ##1 wel_q)
        else $error("latch not set by the set command");

    chk_wel_clear: assert property (
        op_done && is_clr_wl |=> !wel_q)
        else $error("latch not cleared by the clear command");

    chk_quad_enter: assert property (
        op_done && is_eq |=> quad_q && QUAD_MODE)
        else $error("quad flag not set by the enter command");

    chk_quad_exit: assert property (
        op_done && (is_ex || is_ed) |=> !quad_q)
        else $error("quad flag not cleared on mode exit");

    chk_sr_bits: assert property (
        (rd_first || rd_again) && !rd_use2
        |=> out_sh_q[0] == 1'b0 && out_sh_q[6] == $past(quad_q)
            && out_sh_q[1] == $past(wel_q))
        else $error("status byte loaded with wrong bits");

    chk_sr2_quad: assert property (
        (rd_first || rd_again) && rd_use2
        |=> out_sh_q[BIT2_QUAD] == $past(quad_q))
        else $error("second status copy of the quad flag differs");

    cov_set_latch: cover property (op_done && is_set_wl);
    cov_wr_ok: cover property (nv_we);
    cov_wr_block: cover property (write_status_cmd_done && wr_block);
    cov_quad_read: cover property (quad_q && rd_first);
endmodule

//--- verilog/smsr_sync.sv
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level
`timescale 1ns/1ps
module smsr_sync #(
    parameter int         W       = 6,
    parameter logic [5:0] RST_VAL = 6'h00
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL[W-1:0];
            dout   <= RST_VAL[W-1:0];
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
